//--- common/uib_cfg.svh
/*
 Offsets, field positions, reset values and timing counts of the
 serial channel's interrupt, baud and handshake registers.
 Assumes a 32-bit Avalon-MM slave port with byte addresses.
*/
// What this block does
// - Interrupt asserts when any status bit and its mask bit are both set.
// - A cleared mask bit keeps its status bit out of the interrupt.
// - Status and mask share one address; reads give status, writes set mask.
// - Status bits show the true source state regardless of mask.
// - Module reset clears latched status bits 7 and 2; bits 1 and 0 stay live copies of their sources.
// - Bit 7 sets on clear-to-send change when handshake interrupt enabled.
// - Bit 2 sets on break start or end; cleared by reset-break-change command.
// - Bit 1 copies receiver ready or FIFO full by mode select bit.
// - Bit 0 copies transmit holding empty.
// - Characters written while transmit holding empty is low are not sent.
// - High byte and low byte concatenate into the bus clock divider.
// - Both divider bytes are write-only and read back as zero.
// - Input port bit 0 returns clear-to-send pin level latched at read.
// - Reading the change register clears the change-of-state status bit.
// - Handshake interrupt enable gates clear-to-send changes into bit 7.
// - Bus clock is divided by the fixed prescaler, then by the divider.
`ifndef UIB_CFG_SVH
`define UIB_CFG_SVH

// ----------------------------------------
// Register word indices (byte address / 4)
// ----------------------------------------
`define UIB_IDX_STATUS   4'h0
`define UIB_IDX_BAUD_HI  4'h1
`define UIB_IDX_BAUD_LO  4'h2
`define UIB_IDX_INPORT   4'h3
`define UIB_IDX_CHANGE   4'h4
`define UIB_IDX_AUX      4'h5
`define UIB_IDX_MODE     4'h6
`define UIB_IDX_CMD      4'h7
`define UIB_IDX_TXDATA   4'h8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define UIB_BIT_COS      7
`define UIB_BIT_BRK      2
`define UIB_BIT_RXSEL    1
`define UIB_BIT_TRANSMIT_HOLDING_EMPTY    0
`define UIB_BIT_CHG_COS  4
`define UIB_BIT_CTS      0
`define UIB_BIT_HS_EN    0
`define UIB_BIT_FFSEL    0
`define UIB_BIT_RST_BRK  0
`define UIB_MASK_VALID   8'h87

// ----------------------------------------
// Reset values and timing counts
// ----------------------------------------
`define UIB_RST_MASK     8'h00
`define UIB_RST_BAUD_HI  8'h00
`define UIB_RST_BAUD_LO  8'h00
`define UIB_RST_CTS      1'b1
`define UIB_DIV_MIN      16'h0002
`define UIB_PRESCALE     32
`define UIB_PRE_W        5
`define UIB_PRE_LAST     5'h1F

`endif

//--- common/uib_pkg.sv
/*
 Types of the serial channel register block.
 Assumes uib_cfg.svh for all numeric constants.
*/
package uib_pkg;

    // ----------------------------------------
    // Bus handshake states (Gray order)
    // ----------------------------------------
    typedef enum logic [1:0]
    {
        UIB_BUS_IDLE = 2'h0,
        UIB_BUS_ACK  = 2'h1
    } uib_bus_state_t;

    typedef logic [7:0] uib_byte_t;

endpackage

//--- logic/uib_regs.sv
/*
 Interrupt status/mask, baud divider, handshake input and transmit
 gate of one serial channel, reached over Avalon-MM with waitrequest.
 Assumes receiver and transmitter engines on the same clock drive the
 ready, full, break-change and holding-empty inputs; the clear-to-send
 pin is asynchronous.
*/
`include "uib_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module uib_regs
(
    input  wire logic                  i_mclk,
    input  wire logic                  i_arst_n,
    input  wire logic [5:0]            i_address,
    input  wire logic                  i_read,
    input  wire logic                  i_write,
    input  wire logic [31:0]           i_writedata,
    input  wire logic [3:0]            i_byteenable,
    output logic      [31:0]           o_readdata,
    output logic                       o_waitrequest,
    input  wire logic                  i_cts_pin_n,
    input  wire logic                  i_break_change,
    input  wire logic                  i_rx_ready,
    input  wire logic                  i_fifo_full,
    input  wire logic                  i_tx_holding_empty,
    output logic                       o_tx_load,
    output uib_pkg::uib_byte_t         o_tx_data,
    output logic                       o_baud_tick,
    output logic                       o_irq
);
    import uib_pkg::*;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    function automatic logic hit
    (
        input logic [3:0] idx,
        input logic [3:0] code
    );
        hit = (idx == code);
    endfunction

    logic [3:0]     idx;
    logic           acc_rd;
    logic           acc_wr;
    uib_bus_state_t state_reg;
    uib_bus_state_t state_next;
    logic           wait_reg;
    logic           wait_next;
    logic [31:0]    rdata_reg;
    logic [31:0]    rdata_next;

    logic [2:0]     sync_reg;
    logic [2:0]     sync_next;
    logic           cts_reg;
    logic           cts_next;
    logic           cts_event;

    logic           cos_reg;
    logic           cos_next;
    logic           chg_reg;
    logic           chg_next;
    logic           brk_reg;
    logic           brk_next;
    uib_byte_t      mask_reg;
    uib_byte_t      mask_next;
    logic           hs_en_reg;
    logic           hs_en_next;
    logic           ffsel_reg;
    logic           ffsel_next;
    uib_byte_t      baud_hi_reg;
    uib_byte_t      baud_hi_next;
    uib_byte_t      baud_lo_reg;
    uib_byte_t      baud_lo_next;
    uib_byte_t      status;
    uib_byte_t      masked;
    logic           irq_reg;
    logic           irq_next;

    logic           tx_load_reg;
    logic           tx_load_next;
    uib_byte_t      tx_data_reg;
    uib_byte_t      tx_data_next;

    logic [15:0]    divider;
    logic [`UIB_PRE_W-1:0] pre_reg;
    logic [`UIB_PRE_W-1:0] pre_next;
    logic [15:0]    div_cnt_reg;
    logic [15:0]    div_cnt_next;
    logic           tick_reg;
    logic           tick_next;

    assign idx    = i_address[5:2];
    assign acc_rd = (state_reg == UIB_BUS_ACK) && i_read;
    assign acc_wr = (state_reg == UIB_BUS_ACK) && i_write && i_byteenable[0];

    // ----------------------------------------
    // Status vector and interrupt
    // ----------------------------------------
    always_comb
    begin
        status                 = 8'h00;
        status[`UIB_BIT_COS]   = cos_reg;
        status[`UIB_BIT_BRK]   = brk_reg;
        // Live copies, never latched, so reset has no say
        status[`UIB_BIT_RXSEL] = ffsel_reg ? i_fifo_full : i_rx_ready;
        status[`UIB_BIT_TRANSMIT_HOLDING_EMPTY] = i_tx_holding_empty;
    end

    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_mask
            assign masked[g] = status[g] & mask_reg[g];
        end
    endgenerate

    always_comb
    begin
        irq_next = |masked;
    end

    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    // One idle cycle then one ack cycle; fixed, easy to check
    always_comb
    begin
        state_next = state_reg;
        wait_next  = 1'b1;
        rdata_next = rdata_reg;
        case (state_reg)
            UIB_BUS_IDLE:
            begin
                if (i_read || i_write)
                begin
                    state_next = UIB_BUS_ACK;
                    wait_next  = 1'b0;
                    rdata_next = 32'h0000_0000;
                    if (i_read)
                    begin
                        case (idx)
                            `UIB_IDX_STATUS:
                            begin
                                rdata_next[7:0] = status;
                            end
                            `UIB_IDX_INPORT:
                            begin
                                rdata_next[`UIB_BIT_CTS] = cts_reg;
                            end
                            `UIB_IDX_CHANGE:
                            begin
                                rdata_next[`UIB_BIT_CHG_COS] = chg_reg;
                                rdata_next[`UIB_BIT_CTS]     = cts_reg;
                            end
                            `UIB_IDX_AUX:
                            begin
                                rdata_next[`UIB_BIT_HS_EN] = hs_en_reg;
                            end
                            `UIB_IDX_MODE:
                            begin
                                rdata_next[`UIB_BIT_FFSEL] = ffsel_reg;
                            end
                            // Divider bytes and unmapped read as zero
                            default:
                            begin
                                rdata_next = 32'h0000_0000;
                            end
                        endcase
                    end
                end
            end
            UIB_BUS_ACK:
            begin
                state_next = UIB_BUS_IDLE;
            end
            default:
            begin
                state_next = UIB_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state_reg <= UIB_BUS_IDLE;
            wait_reg  <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            state_reg <= state_next;
            wait_reg  <= wait_next;
            rdata_reg <= rdata_next;
        end
    end

    // ----------------------------------------
    // Clear-to-send synchroniser
    // ----------------------------------------
    // Level moves only when stages two and three agree
    always_comb
    begin
        sync_next = {sync_reg[1:0], i_cts_pin_n};
        cts_event = (sync_reg[1] == sync_reg[2]) && (sync_reg[2] != cts_reg);
        cts_next  = cts_event ? sync_reg[2] : cts_reg;
    end

    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            sync_reg <= {3{`UIB_RST_CTS}};
            cts_reg  <= `UIB_RST_CTS;
        end
        else
        begin
            sync_reg <= sync_next;
            cts_reg  <= cts_next;
        end
    end

    // ----------------------------------------
    // Flags and control registers
    // ----------------------------------------
    // Set beats clear in the same cycle, so no event is lost
    always_comb
    begin
        cos_next     = cos_reg;
        chg_next     = chg_reg;
        brk_next     = brk_reg;
        mask_next    = mask_reg;
        hs_en_next   = hs_en_reg;
        ffsel_next   = ffsel_reg;
        baud_hi_next = baud_hi_reg;
        baud_lo_next = baud_lo_reg;
        if (acc_rd && hit(idx, `UIB_IDX_CHANGE))
        begin
            cos_next = 1'b0;
            chg_next = 1'b0;
        end
        if (cts_event)
        begin
            chg_next = 1'b1;
            if (hs_en_reg)
            begin
                cos_next = 1'b1;
            end
        end
        if (acc_wr && hit(idx, `UIB_IDX_CMD) && i_writedata[`UIB_BIT_RST_BRK])
        begin
            brk_next = 1'b0;
        end
        if (i_break_change)
        begin
            brk_next = 1'b1;
        end
        if (acc_wr && hit(idx, `UIB_IDX_STATUS))
        begin
            mask_next = i_writedata[7:0] & `UIB_MASK_VALID;
        end
        if (acc_wr && hit(idx, `UIB_IDX_AUX))
        begin
            hs_en_next = i_writedata[`UIB_BIT_HS_EN];
        end
        if (acc_wr && hit(idx, `UIB_IDX_MODE))
        begin
            ffsel_next = i_writedata[`UIB_BIT_FFSEL];
        end
        if (acc_wr && hit(idx, `UIB_IDX_BAUD_HI))
        begin
            baud_hi_next = i_writedata[7:0];
        end
        if (acc_wr && hit(idx, `UIB_IDX_BAUD_LO))
        begin
            baud_lo_next = i_writedata[7:0];
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            cos_reg     <= 1'b0;
            chg_reg     <= 1'b0;
            brk_reg     <= 1'b0;
            mask_reg    <= `UIB_RST_MASK;
            hs_en_reg   <= 1'b0;
            ffsel_reg   <= 1'b0;
            baud_hi_reg <= `UIB_RST_BAUD_HI;
            baud_lo_reg <= `UIB_RST_BAUD_LO;
            irq_reg     <= 1'b0;
        end
        else
        begin
            cos_reg     <= cos_next;
            chg_reg     <= chg_next;
            brk_reg     <= brk_next;
            mask_reg    <= mask_next;
            hs_en_reg   <= hs_en_next;
            ffsel_reg   <= ffsel_next;
            baud_hi_reg <= baud_hi_next;
            baud_lo_reg <= baud_lo_next;
            irq_reg     <= irq_next;
        end
    end

    // ----------------------------------------
    // Transmit holding gate
    // ----------------------------------------
    // A write with the holding register full is dropped here
    always_comb
    begin
        tx_load_next = acc_wr && hit(idx, `UIB_IDX_TXDATA) && i_tx_holding_empty;
        tx_data_next = tx_load_next ? i_writedata[7:0] : tx_data_reg;
    end

    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            tx_load_reg <= 1'b0;
            tx_data_reg <= 8'h00;
        end
        else
        begin
            tx_load_reg <= tx_load_next;
            tx_data_reg <= tx_data_next;
        end
    end

    // ----------------------------------------
    // Baud generator
    // ----------------------------------------
    // Divider below minimum stops the tick rather than run too fast
    assign divider = {baud_hi_reg, baud_lo_reg};

    always_comb
    begin
        pre_next     = pre_reg;
        div_cnt_next = div_cnt_reg;
        tick_next    = 1'b0;
        if (divider < `UIB_DIV_MIN)
        begin
            pre_next     = '0;
            div_cnt_next = 16'h0000;
        end
        else
        begin
            pre_next = pre_reg + `UIB_PRE_W'(1);
            if (pre_reg == `UIB_PRE_LAST)
            begin
                if (div_cnt_reg >= divider - 16'h0001)
                begin
                    div_cnt_next = 16'h0000;
                    tick_next    = 1'b1;
                end
                else
                begin
                    div_cnt_next = div_cnt_reg + 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            pre_reg     <= '0;
            div_cnt_reg <= 16'h0000;
            tick_reg    <= 1'b0;
        end
        else
        begin
            pre_reg     <= pre_next;
            div_cnt_reg <= div_cnt_next;
            tick_reg    <= tick_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign o_readdata    = rdata_reg;
    assign o_waitrequest = wait_reg;
    assign o_tx_load     = tx_load_reg;
    assign o_tx_data     = tx_data_reg;
    assign o_baud_tick   = tick_reg;
    assign o_irq         = irq_reg;

endmodule

`default_nettype wire

//--- verification/uib_far_end.sv
/*
 Far side model: clear-to-send device and transmit engine.
 Assumes the bench sets the pin level and whether the engine stalls.
*/
`timescale 1ns/10ps
`default_nettype none

module uib_far_end
(
    input  wire logic         i_mclk,
    input  wire logic         i_arst_n,
    input  wire logic         i_cts_level,
    input  wire logic         i_hold,
    input  wire logic         i_tx_load,
    input  wire uib_pkg::uib_byte_t i_tx_data,
    output logic              o_cts_pin_n,
    output logic              o_tx_holding_empty,
    output uib_pkg::uib_byte_t o_last_char,
    output logic [7:0]        o_loads
);
    import uib_pkg::*;

    assign o_cts_pin_n = i_cts_level;

    // Holding register stays full while the engine stalls
    always_ff @(posedge i_mclk or negedge i_arst_n)
        if (!i_arst_n)
        begin
            o_tx_holding_empty <= 1'b1;
            o_last_char        <= 8'h00;
            o_loads            <= 8'h00;
        end
        else if (i_tx_load)
        begin
            o_tx_holding_empty <= 1'b0;
            o_last_char        <= i_tx_data;
            o_loads            <= o_loads + 8'h01;
        end
        else if (!i_hold)
            o_tx_holding_empty <= 1'b1;
endmodule
`default_nettype wire

//--- verification/uib_regs_assertions.sv
/*
 Port checker of the serial channel register block.
 Assumes it is bound to uib_regs and sees its ports only.
*/
`include "uib_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module uib_regs_assertions
(
    input  wire logic        i_mclk,
    input  wire logic        i_arst_n,
    input  wire logic [5:0]  i_address,
    input  wire logic        i_read,
    input  wire logic        i_write,
    input  wire logic [31:0] i_writedata,
    input  wire logic [3:0]  i_byteenable,
    input  wire logic [31:0] o_readdata,
    input  wire logic        o_waitrequest,
    input  wire logic        i_tx_holding_empty,
    input  wire logic        o_tx_load,
    input  wire logic [7:0]  o_tx_data,
    input  wire logic        o_baud_tick,
    input  wire logic        o_irq
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);

    logic       ack_rd;
    logic [3:0] idx;
    assign ack_rd = i_read && !o_waitrequest;
    assign idx    = i_address[5:2];

    // ----------------------------------------
    // Bus answer
    // ----------------------------------------
    sequence s_ack;
        !o_waitrequest ##1 o_waitrequest;
    endsequence
    property p_ack_once;
        $fell(o_waitrequest) |-> s_ack;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack not one cycle");
    property p_ack_bound;
        (i_read || i_write) && o_waitrequest |-> ##[1:3] s_ack;
    endproperty
    a_ack_bound: assert property (p_ack_bound) else $error("no bus answer");
    property p_div_wo;
        ack_rd && (idx == `UIB_IDX_BAUD_HI || idx == `UIB_IDX_BAUD_LO) |-> o_readdata == 32'h0;
    endproperty
    a_div_wo: assert property (p_div_wo) else $error("divider readable");
    property p_unmapped;
        ack_rd && idx > `UIB_IDX_TXDATA |-> o_readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
    // Only when the source held still, since the read is registered
    property p_transmit_holding_empty;
        ack_rd && idx == `UIB_IDX_STATUS
        && $past(i_tx_holding_empty) == $past(i_tx_holding_empty, 2)
        |-> o_readdata[0] == $past(i_tx_holding_empty);
    endproperty
    a_transmit_holding_empty: assert property (p_transmit_holding_empty) else $error("status bit0 wrong");

    // ----------------------------------------
    // Transmit gate, tick, interrupt
    // ----------------------------------------
    sequence s_load;
        o_tx_load ##1 !o_tx_load;
    endsequence
    property p_tx_gate;
        o_tx_load |-> $past(i_write && !o_waitrequest && i_tx_holding_empty)
            && $past(idx) == `UIB_IDX_TXDATA;
    endproperty
    a_tx_gate: assert property (p_tx_gate) else $error("load without ready");
    property p_tx_take;
        i_write && !o_waitrequest && i_byteenable[0] && idx == `UIB_IDX_TXDATA
        && i_tx_holding_empty |=> s_load;
    endproperty
    a_tx_take: assert property (p_tx_take) else $error("load missing");
    property p_tx_data;
        o_tx_load |-> o_tx_data == $past(i_writedata[7:0]);
    endproperty
    a_tx_data: assert property (p_tx_data) else $error("load data wrong");
    property p_tick_gap;
        o_baud_tick |=> !o_baud_tick [*8];
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");
    property p_irq_rst;
        $rose(i_arst_n) |-> !o_irq;
    endproperty
    a_irq_rst: assert property (p_irq_rst) else $error("irq after reset");
endmodule

bind uib_regs uib_regs_assertions u_chk
(
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .i_tx_holding_empty(i_tx_holding_empty), .o_tx_load(o_tx_load),
    .o_tx_data(o_tx_data), .o_baud_tick(o_baud_tick), .o_irq(o_irq)
);
`default_nettype wire

//--- verification/uib_regs_tb_top.sv
/*
 Self-checking bench of the register block with far side model.
 Assumes the checker is bound from its own file.
*/
`include "uib_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module uib_regs_tb_top;
    import uib_pkg::*;

    logic        i_mclk = 0, i_arst_n = 0, i_read = 0, i_write = 0, i_break_change = 0;
    logic        i_rx_ready = 0, i_fifo_full = 0, cts = 1, hold = 0, ee;
    logic [5:0]  i_address = 6'h00;
    logic [31:0] i_writedata = 32'h0, q, r = 32'hC54C2895;
    logic [31:0] o_readdata;
    logic        o_waitrequest, o_tx_load, o_baud_tick, o_irq, pin_n, empty;
    uib_byte_t   o_tx_data, last;
    logic [7:0]  loads, el;
    int          num_errors = 0, checks = 0;

    uib_regs DUT
    (
        .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_address(i_address), .i_read(i_read),
        .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(4'hF),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_cts_pin_n(pin_n),
        .i_break_change(i_break_change), .i_rx_ready(i_rx_ready),
        .i_fifo_full(i_fifo_full), .i_tx_holding_empty(empty), .o_tx_load(o_tx_load),
        .o_tx_data(o_tx_data), .o_baud_tick(o_baud_tick), .o_irq(o_irq)
    );
    uib_far_end u_far
    (
        .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_cts_level(cts), .i_hold(hold),
        .i_tx_load(o_tx_load), .i_tx_data(o_tx_data), .o_cts_pin_n(pin_n),
        .o_tx_holding_empty(empty), .o_last_char(last), .o_loads(loads)
    );

    initial forever #2.5 i_mclk = ~i_mclk;

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // Holds the request until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        i_address   <= {idx, 2'h0};
        i_writedata <= {24'h0, d};
        i_write     <= w;
        i_read      <= !w;
        do begin @(posedge i_mclk); n++; end while (o_waitrequest !== 1'b0 && n < 64);
        if (n >= 64) chk("waitrequest", o_waitrequest, 32'h0);
        q = o_readdata;
        i_write <= 1'b0;
        i_read  <= 1'b0;
        repeat (3) @(posedge i_mclk);
    endtask

    task automatic rst;
        i_arst_n <= 1'b0;
        repeat (6) @(posedge i_mclk);
        i_arst_n <= 1'b1;
        @(posedge i_mclk);
    endtask

    task automatic brk;
        i_break_change <= 1'b1;
        @(posedge i_mclk);
        i_break_change <= 1'b0;
        repeat (2) @(posedge i_mclk);
    endtask

    task automatic gap(input int exp);
        int n;
        n = 0;
        do @(negedge i_mclk); while (o_baud_tick !== 1'b1 && ++n < 20000);
        n = 0;
        do begin @(negedge i_mclk); n++; end while (o_baud_tick !== 1'b1 && n < 20000);
        chk("tick gap", n, exp);
        @(posedge i_mclk);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Sized well above two long divider gaps plus the register traffic
    initial
    begin
        repeat (60000) @(posedge i_mclk);
        num_errors++;
        print_verdict();
    end

    initial
    begin
        rst();
        bus(0, `UIB_IDX_STATUS, 0); chk("status rst", q & 32'h84, 0);
        bus(0, `UIB_IDX_BAUD_HI, 0); chk("div hi", q, 0);
        bus(0, `UIB_IDX_BAUD_LO, 0); chk("div lo", q, 0);
        bus(0, 4'hA, 0); chk("unmapped", q, 0);
        bus(1, `UIB_IDX_STATUS, 8'h04);
        brk();
        bus(0, `UIB_IDX_STATUS, 0); chk("brk", q[2], 1);
        chk("irq on", o_irq, 1);
        bus(1, `UIB_IDX_STATUS, 8'h00); chk("irq masked", o_irq, 0);
        bus(0, `UIB_IDX_STATUS, 0); chk("brk masked", q[2], 1);
        bus(1, `UIB_IDX_STATUS, 8'h04);
        rst();
        bus(0, `UIB_IDX_STATUS, 0); chk("brk rst", q[2], 0);
        brk();
        bus(1, `UIB_IDX_CMD, 8'h01);
        bus(0, `UIB_IDX_STATUS, 0); chk("brk clr", q[2], 0);
        $display("done: break and mask");
        bus(1, `UIB_IDX_STATUS, 8'h80);
        cts <= 1'b0;
        repeat (8) @(posedge i_mclk);
        bus(0, `UIB_IDX_STATUS, 0); chk("cos off", q[7], 0);
        bus(0, `UIB_IDX_INPORT, 0); chk("cts lo", q[0], 0);
        bus(0, `UIB_IDX_CHANGE, 0); chk("chg", q[4], 1);
        bus(1, `UIB_IDX_AUX, 8'h01);
        cts <= 1'b1;
        repeat (8) @(posedge i_mclk);
        bus(0, `UIB_IDX_STATUS, 0); chk("cos on", q[7], 1);
        chk("irq cos", o_irq, 1);
        bus(0, `UIB_IDX_INPORT, 0); chk("cts hi", q[0], 1);
        bus(0, `UIB_IDX_CHANGE, 0);
        bus(0, `UIB_IDX_STATUS, 0); chk("cos clr", q[7], 0);
        $display("done: handshake");
        bus(1, `UIB_IDX_STATUS, 8'h03);
        ee = 1'b1;
        el = 8'h00;
        for (int i = 0; i < 24; i++)
        begin
            r = lfsr(r);
            i_rx_ready  <= r[0];
            i_fifo_full <= r[1];
            hold        <= r[3];
            // Released engine drains the holding register before the next write
            ee = ee || !r[3];
            bus(1, `UIB_IDX_MODE, {7'h0, r[2]});
            if (r[4])
            begin
                bus(1, `UIB_IDX_TXDATA, r[15:8]);
                if (ee) el++;
                if (ee) chk("char", last, r[15:8]);
            end
            ee = !r[3] || (ee && !r[4]);
            bus(0, `UIB_IDX_STATUS, 0);
            chk("rx tx bits", q[1:0], {r[2] ? r[1] : r[0], ee});
            chk("loads", loads, el);
            chk("irq live", o_irq, (r[2] ? r[1] : r[0]) | ee);
        end
        hold <= 1'b0;
        $display("done: random status");
        bus(1, `UIB_IDX_BAUD_HI, 8'h00);
        bus(1, `UIB_IDX_BAUD_LO, 8'h03);
        gap(96);
        bus(1, `UIB_IDX_BAUD_HI, 8'h01);
        bus(1, `UIB_IDX_BAUD_LO, 8'h02);
        gap(8256);
        $display("done: baud");
        print_verdict();
    end
endmodule
`default_nettype wire
